// >>> pkg/hpp_pkg.sv
// constants for the parallel host port: control bits, host map, pin roles
package hpp_pkg;
    // port control word bit positions
    localparam int CTL_W = 16;
    localparam int C_HEN = 0;
    localparam int C_MUX = 1;
    localparam int C_DSTB = 2;
    localparam int C_DREQ = 3;
    localparam int C_AS_HI = 4;
    localparam int C_CS_HI = 5;
    localparam int C_DS_HI = 6;
    localparam int C_WR_HI = 7;
    localparam int C_REQ_HI = 8;
    localparam int C_ACK_HI = 9;
    localparam int C_REQ_OD = 10;
    localparam int C_RRQ_HI = 11;
    localparam int C_RRQ_OD = 12;
    localparam int C_TREQ_EN = 13;
    localparam int C_RREQ_EN = 14;
    localparam logic [15:0] CTL_RST = 16'h0000;
    // pin roles
    localparam int PINS = 16;
    localparam int P_AS = 8;
    localparam int P_A1 = 9;
    localparam int P_A2 = 10;
    localparam int P_RD = 11;
    localparam int P_WR = 12;
    localparam int P_CS = 13;
    localparam int P_REQ = 14;
    localparam int P_ACK = 15;
    // host-visible register addresses
    localparam logic [2:0] A_VEC = 3'h1;
    localparam logic [2:0] A_STAT = 3'h2;
    localparam logic [2:0] A_HIGH = 3'h5;
    localparam logic [2:0] A_MID = 3'h6;
    localparam logic [2:0] A_LOW = 3'h7;
    localparam int S_RXF = 0;
    localparam int S_TXE = 1;
    localparam int S_HC = 2;
    localparam int V_HC = 7;
    localparam logic [7:0] MUX_PAGE_RST = 8'h00;
    localparam int WORD_W = 24;
    typedef enum logic [1:0] {
        HPP_IDLE = 2'b01,
        HPP_BUSY = 2'b10
    } hpp_state_type;
endpackage

// >>> logic/hpp_buf.sv
// two-entry buffer, valid/ready both sides, registered read data
`timescale 1ns/1ps
module hpp_buf #(
    parameter int W = 24
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] spare;
    logic spare_v;
    logic push;
    logic pop;

    assign in_ready = !spare_v;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_data <= '0;
            out_valid <= 1'b0;
            spare <= '0;
            spare_v <= 1'b0;
        end else if (pop) begin
            if (spare_v) begin
                out_data <= spare;
                spare_v <= 1'b0;
            end else begin
                out_data <= in_data;
                out_valid <= push;
            end
        end else if (push) begin
            if (!out_valid) begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end else begin
                spare <= in_data;
                spare_v <= 1'b1;
            end
        end
    end
endmodule

// >>> logic/hpp_top.sv
// parallel host port pin logic, host byte registers and gpio fallback
`timescale 1ns/1ps
// Function
// R01 - a 16-bit port control word selects every pin function
// R02 - host reads receive bytes only after the receive full flag sets
// R03 - host writes transmit bytes only while the transmit empty flag is set
// R04 - host changes the vector only while the command bit is clear
// R05 - non-multiplexed mode: eight pins are bidirectional data lines 0-7
// R06 - multiplexed mode: same eight pins carry address and data 0-7
// R07 - multiplexed mode: address strobe input, polarity programmable, low default
// R08 - multiplexed mode: three dedicated pins give address bits 8, 9, 10
// R09 - non-multiplexed mode: three address inputs pick the host register
// R10 - non-multiplexed mode: access only while chip select is active; an active acknowledge also starts a low byte access without it
// R11 - single-strobe mode: read/write input sets access direction
// R12 - single-strobe mode: one data strobe times transfers, low default
// R13 - double-strobe mode: separate read strobe, low default
// R14 - double-strobe mode: separate write strobe, low default
// R15 - single-request mode: one request output, polarity and drive selectable
// R16 - single-request mode: acknowledge input with programmable polarity
// R17 - double-request mode: transmit request on request pin
// R18 - double-request mode: receive request on acknowledge pin
// R19 - gpio mode: each of sixteen pins is input or output by direction
// R20 - host strobes are synchronised before flags update
// R21 - pins are ignored inputs in reset, active-low defaults after
module hpp_top #(
    parameter logic [7:0] MUX_PAGE = hpp_pkg::MUX_PAGE_RST
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [hpp_pkg::CTL_W-1:0] port_ctrl,
    input wire logic [hpp_pkg::PINS-1:0] gpio_dir,
    input wire logic [hpp_pkg::PINS-1:0] gpio_out,
    output logic [hpp_pkg::PINS-1:0] gpio_in,
    input wire logic [hpp_pkg::PINS-1:0] pin_in,
    output logic [hpp_pkg::PINS-1:0] pin_out,
    output logic [hpp_pkg::PINS-1:0] pin_oe,
    output logic [hpp_pkg::WORD_W-1:0] core_rx_data,
    output logic core_rx_valid,
    input wire logic core_rx_ready,
    input wire logic [hpp_pkg::WORD_W-1:0] core_tx_data,
    input wire logic core_tx_valid,
    output logic core_tx_ready,
    output logic [6:0] host_vector_value,
    output logic host_command_bit,
    input wire logic core_hc_clear,
    output logic receive_full_flag,
    output logic transmit_empty_flag
);
    import hpp_pkg::*;

    function automatic logic act(input logic lvl, input logic high);
        act = high ? lvl : !lvl;
    endfunction

    logic [CTL_W-1:0] cfg;
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] pins;
    logic [10:0] mux_addr;
    hpp_state_type state;
    logic acc_read;
    logic [2:0] acc_addr;
    logic [7:0] wdata;
    logic [7:0] rd_data;
    logic [7:0] tx_high;
    logic [7:0] tx_mid;
    logic [7:0] tx_low;
    logic tx_pending;
    logic [7:0] receive_byte_high;
    logic [7:0] receive_byte_middle;
    logic [7:0] receive_byte_low;
    logic buf_in_ready;
    logic host_en;
    logic as_act;
    logic cs_act;
    logic ack_act;
    logic rd_act;
    logic wr_act;
    logic strobe;
    logic dir_read;
    logic sel;
    logic [2:0] sel_addr;
    logic commit;
    logic wr_commit;
    logic rxl_read;
    logic hc_set;
    logic rx_load;
    logic req_tx;
    logic req_rx;
    logic req_any;

    // control word latched, active-low polarities after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= CTL_RST; // R21
        end else begin
            cfg <= port_ctrl; // R01
        end
    end

    // two-stage pin synchroniser
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            pins <= '0;
        end else begin
            sync1 <= pin_in;
            pins <= sync1; // R20
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_in <= '0;
        end else begin
            gpio_in <= pins;
        end
    end

    // strobe and select decode
    always_comb begin
        host_en = cfg[C_HEN];
        as_act = act(pins[P_AS], cfg[C_AS_HI]); // R07
        cs_act = act(pins[P_CS], cfg[C_CS_HI]); // R10
        ack_act = !cfg[C_DREQ] && act(pins[P_ACK], cfg[C_ACK_HI]); // R16
        rd_act = act(pins[P_RD], cfg[C_DS_HI]); // R13
        wr_act = act(pins[P_WR], cfg[C_WR_HI]); // R14
        if (cfg[C_DSTB]) begin
            strobe = rd_act || wr_act;
            dir_read = rd_act;
        end else begin
            strobe = act(pins[P_WR], cfg[C_DS_HI]); // R12
            dir_read = pins[P_RD]; // R11
        end
        if (ack_act) begin
            sel = 1'b1;
            sel_addr = A_LOW;
        end else if (cfg[C_MUX]) begin
            sel = mux_addr[10:3] == MUX_PAGE; // R08
            sel_addr = mux_addr[2:0];
        end else begin
            sel = cs_act; // R10
            sel_addr = {pins[P_A2], pins[P_A1], pins[P_AS]}; // R09
        end
    end

    // multiplexed address follows the shared lines and the three dedicated pins while the address strobe is active
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mux_addr <= '0;
        end else if (host_en && cfg[C_MUX] && as_act) begin
            mux_addr <= {pins[P_CS], pins[P_A2], pins[P_A1], pins[7:0]}; // R06
        end
    end

    // access tracker, commits on strobe release
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= HPP_IDLE;
            acc_read <= 1'b0;
            acc_addr <= '0;
            wdata <= '0;
        end else begin
            case (state)
                HPP_IDLE: begin
                    if (host_en && strobe && sel) begin
                        state <= HPP_BUSY;
                        acc_read <= dir_read;
                        acc_addr <= sel_addr;
                        wdata <= pins[7:0];
                    end
                end
                HPP_BUSY: begin
                    wdata <= pins[7:0];
                    if (!strobe || !host_en) begin
                        state <= HPP_IDLE;
                    end
                end
                default: begin
                    state <= HPP_IDLE;
                end
            endcase
        end
    end

    assign commit = (state == HPP_BUSY) && (!strobe || !host_en); // R20
    assign wr_commit = commit && !acc_read;
    assign rxl_read = commit && acc_read && (acc_addr == A_LOW);
    assign hc_set = wr_commit && (acc_addr == A_VEC) && wdata[V_HC];
    assign rx_load = core_tx_valid && core_tx_ready;
    assign core_tx_ready = !receive_full_flag;

    // transmit bytes, word moves on low byte write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_high <= '0;
            tx_mid <= '0;
            tx_low <= '0;
            tx_pending <= 1'b0;
        end else begin
            if (wr_commit && acc_addr == A_HIGH) begin
                tx_high <= wdata;
            end
            if (wr_commit && acc_addr == A_MID) begin
                tx_mid <= wdata;
            end
            if (wr_commit && acc_addr == A_LOW) begin
                tx_low <= wdata;
                tx_pending <= 1'b1; // R03
            end else if (buf_in_ready) begin
                tx_pending <= 1'b0;
            end
        end
    end

    assign transmit_empty_flag = !tx_pending;

    hpp_buf #(
        .W(WORD_W)
    ) u_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data({tx_high, tx_mid, tx_low}),
        .in_valid(tx_pending),
        .in_ready(buf_in_ready),
        .out_data(core_rx_data),
        .out_valid(core_rx_valid),
        .out_ready(core_rx_ready)
    );

    // receive bytes from the core, full until host reads low byte
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            receive_byte_high <= '0;
            receive_byte_middle <= '0;
            receive_byte_low <= '0;
            receive_full_flag <= 1'b0;
        end else if (rx_load) begin
            receive_byte_high <= core_tx_data[23:16];
            receive_byte_middle <= core_tx_data[15:8];
            receive_byte_low <= core_tx_data[7:0];
            receive_full_flag <= 1'b1; // R02
        end else if (rxl_read) begin
            receive_full_flag <= 1'b0;
        end
    end

    // host command and vector, set wins over core clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_vector_value <= '0;
            host_command_bit <= 1'b0;
        end else begin
            if (wr_commit && acc_addr == A_VEC && !host_command_bit) begin
                host_vector_value <= wdata[6:0]; // R04
            end
            if (hc_set) begin
                host_command_bit <= 1'b1;
            end else if (core_hc_clear) begin
                host_command_bit <= 1'b0;
            end
        end
    end

    // read data for the host
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0;
        end else if (acc_addr == A_HIGH) begin
            rd_data <= receive_byte_high;
        end else if (acc_addr == A_MID) begin
            rd_data <= receive_byte_middle;
        end else if (acc_addr == A_LOW) begin
            rd_data <= receive_byte_low;
        end else if (acc_addr == A_STAT) begin
            rd_data <= {5'h00, host_command_bit, transmit_empty_flag, receive_full_flag};
        end else if (acc_addr == A_VEC) begin
            rd_data <= {host_command_bit, host_vector_value};
        end else begin
            rd_data <= 8'h00;
        end
    end

    assign req_tx = cfg[C_TREQ_EN] && transmit_empty_flag;
    assign req_rx = cfg[C_RREQ_EN] && receive_full_flag;
    assign req_any = req_tx || req_rx;

    // pin drivers, registered
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i] <= 1'b0; // R21
                end else if (!host_en) begin
                    pin_out[i] <= gpio_out[i];
                    pin_oe[i] <= gpio_dir[i]; // R19
                end else if (i < 8) begin
                    pin_out[i] <= rd_data[i % 8];
                    pin_oe[i] <= (state == HPP_BUSY) && acc_read && strobe; // R05
                end else if (i == P_REQ) begin
                    if (cfg[C_DREQ]) begin
                        pin_out[i] <= req_tx ~^ cfg[C_REQ_HI]; // R17
                        pin_oe[i] <= !cfg[C_REQ_OD] || (req_tx != cfg[C_REQ_HI]);
                    end else begin
                        pin_out[i] <= req_any ~^ cfg[C_REQ_HI]; // R15
                        pin_oe[i] <= !cfg[C_REQ_OD] || (req_any != cfg[C_REQ_HI]);
                    end
                end else if (i == P_ACK && cfg[C_DREQ]) begin
                    pin_out[i] <= req_rx ~^ cfg[C_RRQ_HI]; // R18
                    pin_oe[i] <= !cfg[C_RRQ_OD] || (req_rx != cfg[C_RRQ_HI]);
                end else begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i] <= 1'b0;
                end
            end
        end
    endgenerate

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_rx_full_set: assert property (rx_load |=> receive_full_flag ##0 !core_tx_ready) // R02
        else $error("receive full flag not set by core load");
    a_tx_hold: assert property (tx_pending && !buf_in_ready |=> !transmit_empty_flag) // R03
        else $error("transmit empty flag set while word is stalled");
    a_hc_set_wins: assert property (hc_set |=> host_command_bit) // R04
        else $error("host command bit lost on set");
    a_data_drive: assert property (host_en && $past(host_en) && pin_oe[0]
        |-> $past(state == HPP_BUSY && acc_read)) // R05
        else $error("data pins driven outside a read");
    a_mux_capture: assert property (host_en && cfg[C_MUX] && as_act && !ack_act
        |=> mux_addr[7:0] == $past(pins[7:0])) // R07
        else $error("multiplexed address not captured");
    a_cs_gate: assert property (state == HPP_IDLE && !cfg[C_MUX] && !ack_act && !cs_act
        |=> state == HPP_IDLE) // R10
        else $error("access started without chip select");
    a_req_level: assert property (host_en && !cfg[C_DREQ]
        |=> pin_out[P_REQ] == ($past(req_any) ~^ $past(cfg[C_REQ_HI]))) // R15
        else $error("request level wrong");
    a_gpio_dir: assert property (!host_en |=> pin_oe == $past(gpio_dir)) // R19
        else $error("gpio direction not applied");
    a_commit_busy: assert property (commit |-> state == HPP_BUSY ##1 state == HPP_IDLE) // R20
        else $error("commit outside a tracked access");
endmodule

// >>> test/hpp_host.sv
// host processor model for the parallel host port pins
`timescale 1ns/1ps
module hpp_host (
    input wire logic ref_clk,
    input wire logic [hpp_pkg::CTL_W-1:0] c,
    input wire logic [hpp_pkg::PINS-1:0] pin_out,
    input wire logic [hpp_pkg::PINS-1:0] pin_oe,
    output logic [hpp_pkg::PINS-1:0] pin_in
);
    import hpp_pkg::*;
    logic [7:0] hd = 8'h00;
    logic hdrv = 1'b0;
    logic [15:8] hp = 8'hFF;
    // released data lines show the inverse of the last value, request pin pulled up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {hp, hdrv ? hd : ~hd});
    // park strobes and selects at their inactive levels
    task automatic idle();
        hdrv <= 1'b0;
        hp <= {~c[C_ACK_HI], 1'b1, ~c[C_CS_HI] & ~c[C_MUX],
            c[C_DSTB] ? ~c[C_WR_HI] : ~c[C_DS_HI], ~c[C_DS_HI], 2'b00, ~c[C_AS_HI]};
    endtask
    // one host access; sel low breaks the chip select or the address page
    task automatic acc(input logic wr, input logic sel, input logic [2:0] a,
        input logic [7:0] wd, output logic [7:0] rd);
        rd = 8'hXX;
        @(posedge ref_clk);
        if (c[C_MUX]) begin
            hd <= {5'h00, a};
            hdrv <= 1'b1;
            hp[P_A1] <= ~sel;
            hp[P_AS] <= c[C_AS_HI];
            repeat (3) @(posedge ref_clk);
            hp[P_AS] <= ~c[C_AS_HI];
            repeat (3) @(posedge ref_clk);
        end else begin
            hp[P_A2:P_AS] <= a;
            hp[P_CS] <= sel ~^ c[C_CS_HI];
        end
        hdrv <= wr;
        hd <= wd;
        if (!c[C_DSTB]) begin
            hp[P_RD] <= ~wr;
            hp[P_WR] <= c[C_DS_HI];
        end else if (wr) hp[P_WR] <= c[C_WR_HI];
        else hp[P_RD] <= c[C_DS_HI];
        // strobe held six cycles, read data taken while the port drives
        repeat (6) begin
            @(posedge ref_clk);
            if (!wr && pin_oe[0]) rd = pin_out[7:0];
        end
        idle();
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// >>> test/tb_host_parallel_port_pins.sv
// self-checking bench for the parallel host port pin logic
`timescale 1ns/1ps
module tb_host_parallel_port_pins;
    import hpp_pkg::*;
    localparam logic [15:0] MODES [5] = '{16'h0001, 16'h0003, 16'h0005, 16'h0071, 16'h02F7};
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] port_ctrl = 16'h0000, gpio_dir = 16'hFFFF, gpio_out = 16'h0000;
    logic [15:0] gpio_in, pin_in, pin_out, pin_oe;
    logic [23:0] core_rx_data, core_tx_data = 24'h000000;
    logic core_rx_valid, core_rx_ready = 1'b0, core_tx_valid = 1'b0, core_tx_ready;
    logic [6:0] host_vector_value;
    logic host_command_bit, core_hc_clear = 1'b0, receive_full_flag, transmit_empty_flag;
    integer seed = 48150, failures = 0, total_checks = 0;
    logic [7:0] rd;
    logic [23:0] w [3];
    logic [23:0] x;
    logic [15:0] c;
    always #2.5 ref_clk = ~ref_clk;
    hpp_top dut (.ref_clk, .nrst, .port_ctrl, .gpio_dir, .gpio_out, .gpio_in, .pin_in,
        .pin_out, .pin_oe, .core_rx_data, .core_rx_valid, .core_rx_ready, .core_tx_data,
        .core_tx_valid, .core_tx_ready, .host_vector_value, .host_command_bit,
        .core_hc_clear, .receive_full_flag, .transmit_empty_flag);
    hpp_host host (.ref_clk, .c(port_ctrl), .pin_out, .pin_oe, .pin_in);
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic quit();
        failures++;
        print_verdict();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // park the host pins with the port disabled, then enable it
    task automatic cfg(input logic [15:0] v);
        @(posedge ref_clk);
        port_ctrl <= v & ~(16'h0001 << C_HEN);
        @(posedge ref_clk);
        host.idle();
        tick(4);
        port_ctrl <= v;
        tick(4);
    endtask
    task automatic core_send(input logic [23:0] v);
        int n;
        @(posedge ref_clk);
        core_tx_data <= v;
        core_tx_valid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (core_tx_ready === 1'b1) break;
        end
        core_tx_valid <= 1'b0;
        if (n == 50) quit();
    endtask
    task automatic core_get(output logic [23:0] v);
        int n;
        @(posedge ref_clk);
        core_rx_ready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (core_rx_valid === 1'b1) break;
        end
        v = core_rx_data;
        core_rx_ready <= 1'b0;
        if (n == 50) quit();
    endtask
    // host waits for an empty transmit side, then writes high, middle, low
    task automatic put_word(input logic [23:0] v);
        int n;
        for (n = 0; n < 50 && transmit_empty_flag !== 1'b1; n++) tick(1);
        if (n == 50) quit();
        for (int i = 5; i < 8; i++) host.acc(1'b1, 1'b1, 3'(i), v[8*(7-i) +: 8], rd);
    endtask
    // host polls the full flag in the status byte, then reads three bytes
    task automatic get_word(output logic [23:0] v);
        int n;
        for (n = 0; n < 20; n++) begin
            host.acc(1'b0, 1'b1, A_STAT, 8'h00, rd);
            if (rd[S_RXF] === 1'b1) break;
        end
        if (n == 20) quit();
        for (int i = 5; i < 8; i++) begin
            host.acc(1'b0, 1'b1, 3'(i), 8'h00, rd);
            v = {v[15:0], rd};
        end
    endtask
    // expected {oe, level} of request pin and receive request pin
    function automatic logic [3:0] req_exp(input logic [15:0] v, input logic rxf);
        logic t, r, a, o14, o15;
        t = v[C_TREQ_EN];
        r = v[C_RREQ_EN] & rxf;
        a = v[C_DREQ] ? t : t | r;
        o14 = v[C_REQ_OD] ? a ^ v[C_REQ_HI] : 1'b1;
        o15 = v[C_DREQ] & (v[C_RRQ_OD] ? r ^ v[C_RRQ_HI] : 1'b1);
        return {o14, o14 & (a ~^ v[C_REQ_HI]), o15, o15 & (r ~^ v[C_RRQ_HI])};
    endfunction
    initial begin
        tick(4);
        check("reset_oe", pin_oe, 16'h0000);
        check("reset_flags", {receive_full_flag, transmit_empty_flag}, 2'b01);
        tick(4);
        nrst <= 1'b1;
        tick(4);
        repeat (4) begin
            @(posedge ref_clk);
            gpio_dir <= 16'($random(seed));
            gpio_out <= 16'($random(seed));
            {host.hp, host.hd} <= 16'($random(seed));
            host.hdrv <= 1'b1;
            tick(6);
            check("gpio_oe", pin_oe, gpio_dir);
            check("gpio_out", pin_out & gpio_dir, gpio_out & gpio_dir);
            check("gpio_in", gpio_in, (gpio_dir & gpio_out) | (~gpio_dir & pin_in));
        end
        gpio_dir <= 16'h0000;
        foreach (MODES[k]) begin
            cfg(MODES[k]);
            w[0] = 24'($random(seed));
            core_send(w[0]);
            tick(2);
            check("rx_full", receive_full_flag, 1'b1);
            get_word(x);
            check("host_read", x, w[0]);
            tick(2);
            check("rx_clear", receive_full_flag, 1'b0);
            w[0] = 24'($random(seed));
            put_word(w[0]);
            core_get(x);
            check("host_write", x, w[0]);
            host.acc(1'b1, 1'b0, A_LOW, 8'h5A, rd);
            tick(6);
            check("deselect", {transmit_empty_flag, core_rx_valid}, 2'b10);
        end
        cfg(16'h0001);
        host.acc(1'b0, 1'b1, 3'h0, 8'hFF, rd);
        check("unmapped", rd, 8'h00);
        x = 24'($random(seed));
        host.acc(1'b1, 1'b1, A_VEC, {1'b1, x[6:0]}, rd);
        tick(2);
        check("vector", {host_command_bit, host_vector_value}, {1'b1, x[6:0]});
        host.acc(1'b1, 1'b1, A_VEC, {1'b1, ~x[6:0]}, rd);
        check("vector_held", host_vector_value, x[6:0]);
        host.acc(1'b0, 1'b1, A_STAT, 8'h00, rd);
        check("status", rd[2:0], 3'b110);
        @(posedge ref_clk);
        core_hc_clear <= 1'b1;
        @(posedge ref_clk);
        core_hc_clear <= 1'b0;
        tick(2);
        check("hc_clear", host_command_bit, 1'b0);
        for (int i = 0; i < 3; i++) begin
            w[i] = 24'($random(seed));
            put_word(w[i]);
        end
        tick(4);
        check("tx_pending", transmit_empty_flag, 1'b0);
        for (int i = 0; i < 3; i++) begin
            core_get(x);
            check("drain", x, w[i]);
        end
        tick(4);
        check("tx_empty", transmit_empty_flag, 1'b1);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) core_send(24'h00A5C3);
            c = 16'h0001 | (16'($random(seed)) & 16'h7F08);
            cfg(c);
            check("request", {pin_oe[14], pin_oe[14] & pin_out[14], pin_oe[15],
                pin_oe[15] & pin_out[15]}, req_exp(c, i >= 8));
        end
        get_word(x);
        check("last_word", x, 24'h00A5C3);
        // acknowledge alone selects the low receive byte, chip select held inactive
        cfg(16'h0001);
        core_send(24'h3C5A96);
        tick(2);
        host.hp[P_ACK] <= 1'b0;
        host.acc(1'b0, 1'b0, 3'h0, 8'h00, rd);
        check("ack_read", {rd, receive_full_flag}, {8'h96, 1'b0});
        print_verdict();
    end
endmodule
